//--- design/dsp_instruction_field_decoder.sv
// Instruction field decoder with pointer, program counter and return stack state
`timescale 1ns/1ps
`default_nettype none
module dsp_instruction_field_decoder #(
    parameter int STACK_DEPTH = 4
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [dsp_decode_pkg::APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INSTR_VALID,
    input wire logic [dsp_decode_pkg::INSTR_W-1:0] INSTR,
    input wire logic [dsp_decode_pkg::IMM_W-1:0] BUS_VALUE,
    input wire dsp_decode_pkg::cond_flags_t FLAGS,
    input wire logic DMA_MODE,
    output dsp_decode_pkg::decode_t DECODE,
    output logic [dsp_decode_pkg::PC_W-1:0] PROGRAM_COUNTER,
    output logic [dsp_decode_pkg::DP_W-1:0] DATA_POINTER,
    output logic [dsp_decode_pkg::RP_W-1:0] COEF_POINTER
);
    import dsp_decode_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // Power of two keeps the stack index wrapping for free
    if (STACK_DEPTH < 2 || STACK_DEPTH > 16 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_depth_check
        $error("STACK_DEPTH must be a power of two from 2 to 16");
    end

    typedef struct packed {
        logic run;
        logic illegal_seen;
        logic over_seen;
        logic under_seen;
        logic [PC_W-1:0] pc;
        logic [DP_W-1:0] dp;
        logic [RP_W-1:0] rp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [SP_W:0] depth;
        logic [INSTR_W-1:0] last;
        logic [31:0] rdata;
        decode_t dec;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic cond_holds;
    logic [1:0] fmt;
    logic [3:0] source_code;
    logic [3:0] dest_code;
    logic [2:0] kind;
    logic take;
    logic [DP_W-1:0] dp_work;
    logic [RP_W-1:0] rp_work;
    logic [IMM_W-1:0] move_value;
    logic [SP_W-1:0] top;
    logic apb_write;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic decode_t source_fields(decode_t d, logic [3:0] code, logic dma);
        d.source = code;
        case (code)
            SOURCE_HOST: begin
                d.host_flag_set = 1'h1;
                d.dma_raise = dma;
            end
            SOURCE_HOST_QUIET: begin
                d.host_flag_set = 1'h0;
                d.dma_raise = 1'h0;
            end
            SOURCE_SERIAL_MSB: d.serial_in_read = 1'h1;
            SOURCE_SERIAL_REV: begin
                d.serial_in_read = 1'h1;
                d.serial_in_reversed = 1'h1;
            end
            SOURCE_RAM: d.ram_read = 1'h1;
            default: d.source = code;
        endcase
        return d;
    endfunction : source_fields

    function automatic decode_t dest_fields(decode_t d, logic [3:0] code, logic dma);
        d.dest = code;
        case (code)
            DEST_HOST: begin
                d.host_flag_set = 1'h1;
                d.dma_raise = dma;
            end
            DEST_SERIAL_LSB: d.serial_out_load = 1'h1;
            DEST_SERIAL_MSB: begin
                d.serial_out_load = 1'h1;
                d.serial_out_msb_first = 1'h1;
            end
            DEST_FACTOR1: d.factor1_from_bus = 1'h1;
            DEST_FACTOR2: d.factor2_from_bus = 1'h1;
            DEST_FACTOR_ROM: begin
                d.factor1_from_bus = 1'h1;
                d.factor2_from_rom = 1'h1;
            end
            DEST_FACTOR_RAM: begin
                d.factor1_from_ram = 1'h1;
                d.factor2_from_bus = 1'h1;
            end
            DEST_RAM: d.ram_write = 1'h1;
            default: d.dest = code;
        endcase
        return d;
    endfunction : dest_fields

    function automatic logic addr_known(logic [APB_AW-1:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_PC) || (a == ADDR_POINTERS) || (a == ADDR_LAST)
            || (a == ADDR_STATUS);
    endfunction : addr_known

    jump_condition_eval u_cond (
        .cond(INSTR[COND_HI:COND_LO]),
        .flags(FLAGS),
        .low_nibble(s_q.dp[3:0]),
        .holds(cond_holds)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        fmt = INSTR[FMT_HI:FMT_LO];
        source_code = INSTR[SOURCE_HI:SOURCE_LO];
        dest_code = INSTR[DEST_HI:DEST_LO];
        kind = INSTR[KIND_HI:KIND_LO];
        take = 1'h0;
        dp_work = s_q.dp;
        rp_work = s_q.rp;
        move_value = BUS_VALUE;
        top = SP_W'(s_q.depth - 1'h1);
        apb_write = PSEL & PENABLE & PWRITE;
        // Write one to clear ahead of the instruction, so an event in the same cycle wins
        if (apb_write && PADDR == ADDR_STATUS) begin
            s_d.illegal_seen = s_q.illegal_seen & ~PWDATA[STAT_ILLEGAL_BIT];
            s_d.over_seen = s_q.over_seen & ~PWDATA[STAT_OVER_BIT];
            s_d.under_seen = s_q.under_seen & ~PWDATA[STAT_UNDER_BIT];
        end
        s_d.dec = '0;
        if (INSTR_VALID && s_q.run) begin
            s_d.last = INSTR;
            s_d.dec.valid = 1'h1;
            s_d.dec.format = fmt;
            // Move uses the pointers as they stood at the start of the cycle
            s_d.dec.ram_addr = s_q.dp;
            s_d.dec.factor_ram_addr = s_q.dp;
            s_d.dec.factor_ram_addr[FORCED_RAM_BIT] = 1'h1;
            s_d.dec.rom_addr = s_q.rp;
            s_d.pc = PC_W'(s_q.pc + 1'h1);
            case (fmt)
                FMT_OPERATE, FMT_RETURN: begin
                    s_d.dec.acc_b = INSTR[ACC_SEL_BIT];
                    s_d.dec.alu_input = INSTR[ALU_IN_HI:ALU_IN_LO];
                    s_d.dec.alu_func = INSTR[ALU_FN_HI:ALU_FN_LO];
                    s_d.dec = source_fields(s_d.dec, source_code, DMA_MODE);
                    s_d.dec = dest_fields(s_d.dec, dest_code, DMA_MODE);
                end
                FMT_JUMP: begin
                    case (kind)
                        KIND_JUMP: take = 1'h1;
                        KIND_CALL: take = 1'h1;
                        KIND_COND: take = cond_holds;
                        default: begin
                            // Prohibited kind: run on, remember it for software
                            take = 1'h0;
                            s_d.illegal_seen = 1'h1;
                        end
                    endcase
                    if (take) begin
                        s_d.pc = INSTR[TARGET_HI:TARGET_LO];
                        s_d.dec.jump_taken = 1'h1;
                    end
                    if (kind == KIND_CALL) begin
                        s_d.dec.calling = 1'h1;
                        if (s_q.depth == (SP_W + 1)'(STACK_DEPTH)) begin
                            // Full stack: newest return address is replaced, older ones survive
                            s_d.over_seen = 1'h1;
                            s_d.stack[top] = PC_W'(s_q.pc + 1'h1);
                        end else begin
                            s_d.stack[SP_W'(s_q.depth)] = PC_W'(s_q.pc + 1'h1);
                            s_d.depth = (SP_W + 1)'(s_q.depth + 1'h1);
                        end
                    end
                end
                FMT_LOAD: begin
                    move_value = INSTR[IMM_HI:IMM_LO];
                    s_d.dec.immediate_on_bus = 1'h1;
                    s_d.dec.immediate_value = INSTR[IMM_HI:IMM_LO];
                    s_d.dec = dest_fields(s_d.dec, dest_code, DMA_MODE);
                end
                default: s_d.dec.valid = 1'h1;
            endcase

            // Pointer loads from the move come first, modifies apply on top
            if (fmt != FMT_JUMP && dest_code == DEST_DATA_POINTER) begin
                dp_work = move_value[DP_W-1:0];
            end
            if (fmt != FMT_JUMP && dest_code == DEST_COEF_POINTER) begin
                rp_work = move_value[RP_W-1:0];
            end
            if (fmt == FMT_OPERATE || fmt == FMT_RETURN) begin
                case (INSTR[LOW_MOD_HI:LOW_MOD_LO])
                    LOW_INC: dp_work[3:0] = 4'(dp_work[3:0] + 1'h1);
                    LOW_DEC: dp_work[3:0] = 4'(dp_work[3:0] - 1'h1);
                    LOW_CLEAR: dp_work[3:0] = 4'h0;
                    default: dp_work[3:0] = dp_work[3:0];
                endcase
                dp_work[6:4] = dp_work[6:4] ^ INSTR[HIGH_MASK_HI:HIGH_MASK_LO];
                if (INSTR[COEF_STEP_BIT]) begin
                    rp_work = RP_W'(rp_work - 1'h1);
                end
            end
            s_d.dp = dp_work;
            s_d.rp = rp_work;

            // Return goes last, after the move and the pointer changes
            if (fmt == FMT_RETURN) begin
                s_d.dec.returning = 1'h1;
                if (s_q.depth == '0) begin
                    s_d.under_seen = 1'h1;
                end else begin
                    s_d.pc = s_q.stack[top];
                    s_d.depth = (SP_W + 1)'(s_q.depth - 1'h1);
                end
            end
        end

        // Software writes land after the instruction of the same cycle
        if (apb_write) begin
            case (PADDR)
                ADDR_CTRL: s_d.run = PWDATA[CTRL_RUN_BIT];
                ADDR_PC: s_d.pc = PWDATA[PC_W-1:0];
                ADDR_POINTERS: begin
                    s_d.dp = PWDATA[DP_W-1:0];
                    s_d.rp = PWDATA[PTR_COEF_LO +: RP_W];
                end
                default: s_d.run = s_d.run;
            endcase
        end

        // Read data is fetched in the setup cycle so the access can end at once
        if (PSEL && !PENABLE) begin
            s_d.rdata = '0;
            case (PADDR)
                ADDR_CTRL: s_d.rdata[CTRL_RUN_BIT] = s_q.run;
                ADDR_PC: s_d.rdata[PC_W-1:0] = s_q.pc;
                ADDR_POINTERS: begin
                    s_d.rdata[DP_W-1:0] = s_q.dp;
                    s_d.rdata[PTR_COEF_LO +: RP_W] = s_q.rp;
                end
                ADDR_LAST: s_d.rdata[INSTR_W-1:0] = s_q.last;
                ADDR_STATUS: begin
                    s_d.rdata[STAT_ILLEGAL_BIT] = s_q.illegal_seen;
                    s_d.rdata[STAT_OVER_BIT] = s_q.over_seen;
                    s_d.rdata[STAT_UNDER_BIT] = s_q.under_seen;
                    s_d.rdata[STAT_DEPTH_LO +: SP_W + 1] = s_q.depth;
                end
                default: s_d.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.run <= CTRL_RUN_RESET;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign DECODE = s_q.dec;
    assign PROGRAM_COUNTER = s_q.pc;
    assign DATA_POINTER = s_q.dp;
    assign COEF_POINTER = s_q.rp;
    assign PRDATA = s_q.rdata;
    // Clock enable low stalls the bus instead of dropping a transfer
    assign PREADY = CE;
    assign PSLVERR = PSEL & PENABLE & ~addr_known(PADDR);

endmodule : dsp_instruction_field_decoder
`default_nettype wire

//--- inc/dsp_decode_pkg.sv
// Constants, encodings and carrier types of the instruction field decoder
package dsp_decode_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int INSTR_W = 23;
    localparam int PC_W = 11;
    localparam int DP_W = 7;
    localparam int RP_W = 9;
    localparam int IMM_W = 16;
    localparam int APB_AW = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int FMT_HI = 22;
    localparam int FMT_LO = 21;
    localparam int ALU_IN_HI = 20;
    localparam int ALU_IN_LO = 19;
    localparam int ALU_FN_HI = 18;
    localparam int ALU_FN_LO = 15;
    localparam int ACC_SEL_BIT = 14;
    localparam int LOW_MOD_HI = 13;
    localparam int LOW_MOD_LO = 12;
    localparam int HIGH_MASK_HI = 11;
    localparam int HIGH_MASK_LO = 9;
    localparam int COEF_STEP_BIT = 8;
    localparam int SOURCE_HI = 7;
    localparam int SOURCE_LO = 4;
    localparam int DEST_HI = 3;
    localparam int DEST_LO = 0;
    localparam int KIND_HI = 20;
    localparam int KIND_LO = 18;
    localparam int COND_HI = 17;
    localparam int COND_LO = 13;
    localparam int TARGET_HI = 12;
    localparam int TARGET_LO = 2;
    localparam int IMM_HI = 20;
    localparam int IMM_LO = 5;
    localparam int FORCED_RAM_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Formats, branch kinds, pointer modifies, low nibble condition
    localparam logic [1:0] FMT_OPERATE = 2'h0;
    localparam logic [1:0] FMT_RETURN = 2'h1;
    localparam logic [1:0] FMT_JUMP = 2'h2;
    localparam logic [1:0] FMT_LOAD = 2'h3;
    localparam logic [2:0] KIND_JUMP = 3'h4;
    localparam logic [2:0] KIND_CALL = 3'h5;
    localparam logic [2:0] KIND_COND = 3'h2;
    localparam logic [1:0] LOW_KEEP = 2'h0;
    localparam logic [1:0] LOW_INC = 2'h1;
    localparam logic [1:0] LOW_DEC = 2'h2;
    localparam logic [1:0] LOW_CLEAR = 2'h3;
    localparam logic [3:0] COND_LOW_NIBBLE = 4'hC;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [3:0] NIBBLE_FULL = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Bus source codes
    localparam logic [3:0] SOURCE_NONE = 4'h0;
    localparam logic [3:0] SOURCE_ACC_A = 4'h1;
    localparam logic [3:0] SOURCE_ACC_B = 4'h2;
    localparam logic [3:0] SOURCE_SCRATCH = 4'h3;
    localparam logic [3:0] SOURCE_DATA_POINTER = 4'h4;
    localparam logic [3:0] SOURCE_COEF_POINTER = 4'h5;
    localparam logic [3:0] SOURCE_ROM = 4'h6;
    localparam logic [3:0] SOURCE_SIGN = 4'h7;
    localparam logic [3:0] SOURCE_HOST = 4'h8;
    localparam logic [3:0] SOURCE_HOST_QUIET = 4'h9;
    localparam logic [3:0] SOURCE_STATUS = 4'hA;
    localparam logic [3:0] SOURCE_SERIAL_MSB = 4'hB;
    localparam logic [3:0] SOURCE_SERIAL_REV = 4'hC;
    localparam logic [3:0] SOURCE_FACTOR1 = 4'hD;
    localparam logic [3:0] SOURCE_FACTOR2 = 4'hE;
    localparam logic [3:0] SOURCE_RAM = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Bus destination codes
    localparam logic [3:0] DEST_NONE = 4'h0;
    localparam logic [3:0] DEST_ACC_A = 4'h1;
    localparam logic [3:0] DEST_ACC_B = 4'h2;
    localparam logic [3:0] DEST_SCRATCH = 4'h3;
    localparam logic [3:0] DEST_DATA_POINTER = 4'h4;
    localparam logic [3:0] DEST_COEF_POINTER = 4'h5;
    localparam logic [3:0] DEST_HOST = 4'h6;
    localparam logic [3:0] DEST_STATUS = 4'h7;
    localparam logic [3:0] DEST_SERIAL_LSB = 4'h8;
    localparam logic [3:0] DEST_SERIAL_MSB = 4'h9;
    localparam logic [3:0] DEST_FACTOR1 = 4'hA;
    localparam logic [3:0] DEST_FACTOR_ROM = 4'hB;
    localparam logic [3:0] DEST_FACTOR_RAM = 4'hC;
    localparam logic [3:0] DEST_FACTOR2 = 4'hD;
    localparam logic [3:0] DEST_NONE_ALT = 4'hE;
    localparam logic [3:0] DEST_RAM = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_PC = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_POINTERS = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_LAST = 8'h0C;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h10;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'h1;
    localparam int PTR_COEF_LO = 16;
    localparam int STAT_ILLEGAL_BIT = 0;
    localparam int STAT_OVER_BIT = 1;
    localparam int STAT_UNDER_BIT = 2;
    localparam int STAT_DEPTH_LO = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic carry_a;
        logic carry_b;
        logic zero_a;
        logic zero_b;
        logic ovf0_a;
        logic ovf0_b;
        logic ovf1_a;
        logic ovf1_b;
        logic sign0_a;
        logic sign0_b;
        logic sign1_a;
        logic sign1_b;
        logic serial_in_ack;
        logic serial_out_ack;
        logic host_request_flag;
    } cond_flags_t;

    typedef struct packed {
        logic valid;
        logic [1:0] format;
        logic acc_b;
        logic [1:0] alu_input;
        logic [3:0] alu_func;
        logic [3:0] source;
        logic [3:0] dest;
        logic host_flag_set;
        logic dma_raise;
        logic serial_in_read;
        logic serial_in_reversed;
        logic serial_out_load;
        logic serial_out_msb_first;
        logic factor1_from_bus;
        logic factor1_from_ram;
        logic factor2_from_bus;
        logic factor2_from_rom;
        logic ram_read;
        logic ram_write;
        logic immediate_on_bus;
        logic [IMM_W-1:0] immediate_value;
        logic [DP_W-1:0] ram_addr;
        logic [DP_W-1:0] factor_ram_addr;
        logic [RP_W-1:0] rom_addr;
        logic jump_taken;
        logic calling;
        logic returning;
    } decode_t;

endpackage : dsp_decode_pkg

//--- design/jump_condition_eval.sv
// Evaluates the condition field of a conditional jump
`timescale 1ns/1ps
`default_nettype none
module jump_condition_eval (
    input wire logic [4:0] cond,
    input wire dsp_decode_pkg::cond_flags_t flags,
    input wire logic [3:0] low_nibble,
    output logic holds
);
    import dsp_decode_pkg::*;

    logic [15:0] flag_vec;

    // Index is the condition code without its polarity bit
    assign flag_vec = {flags.host_request_flag, flags.serial_out_ack, flags.serial_in_ack, 1'h0,
                       flags.sign1_b, flags.sign1_a, flags.sign0_b, flags.sign0_a,
                       flags.ovf1_b, flags.ovf1_a, flags.ovf0_b, flags.ovf0_a,
                       flags.zero_b, flags.zero_a, flags.carry_b, flags.carry_a};

    always_comb begin
        if (cond[4:1] == COND_LOW_NIBBLE) begin
            // Nibble test: polarity picks all-ones over zero
            holds = cond[0] ? (low_nibble == NIBBLE_FULL) : (low_nibble == NIBBLE_ZERO);
        end else begin
            holds = (flag_vec[cond[4:1]] == cond[0]);
        end
    end
endmodule : jump_condition_eval
`default_nettype wire

//--- tb/dec_chk_assertions.sv
// Checker of decode timing, fields and pointer updates at the decoder ports
`timescale 1ns/1ps
`default_nettype none
module dec_chk (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic INSTR_VALID,
    input wire logic [dsp_decode_pkg::INSTR_W-1:0] INSTR,
    input wire dsp_decode_pkg::decode_t DECODE,
    input wire logic [dsp_decode_pkg::PC_W-1:0] PROGRAM_COUNTER,
    input wire logic [dsp_decode_pkg::DP_W-1:0] DATA_POINTER,
    input wire logic [dsp_decode_pkg::RP_W-1:0] COEF_POINTER
);
    import dsp_decode_pkg::*;
    logic [3:0] nib_next;
    logic [2:0] high_next;
    logic [RP_W-1:0] coef_next;
    logic [PC_W-1:0] pc_next;
    // Pointer values expected after the word, compared one cycle later
    always_comb begin
        nib_next = INSTR[13:12] == LOW_CLEAR ? 4'h0 : DATA_POINTER[3:0] + (INSTR[12] ? 4'h1 : {4{INSTR[13]}});
        high_next = DATA_POINTER[6:4] ^ INSTR[11:9];
        coef_next = COEF_POINTER - {8'h00, INSTR[8]};
        pc_next = PROGRAM_COUNTER + 11'h001;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence took_s;
        CE && INSTR_VALID;
    endsequence
    // Pointer-loading destinations left out: they replace the pointer that the modify fields then start from
    sequence took_op_s;
        took_s ##0 !INSTR[22] && INSTR[3:1] != 3'h2;
    endsequence
    take_answer_a: assert property (took_s |=> DECODE.valid)
        else $error("no decode after a taken word");
    acc_choice_a: assert property (took_op_s |=> DECODE.acc_b == $past(INSTR[14]))
        else $error("accumulator choice wrong");
    src_dest_a: assert property (took_op_s |=> {DECODE.source, DECODE.dest} == $past(INSTR[7:0]))
        else $error("source or destination wrong");
    low_nibble_a: assert property (took_op_s |=> DATA_POINTER[3:0] == $past(nib_next))
        else $error("low pointer nibble wrong");
    high_mask_a: assert property (took_op_s |=> DATA_POINTER[6:4] == $past(high_next))
        else $error("high pointer bits wrong");
    coef_step_a: assert property (took_op_s |=> COEF_POINTER == $past(coef_next))
        else $error("coefficient pointer wrong");
    op_advance_a: assert property (took_op_s ##0 !INSTR[21] |=> PROGRAM_COUNTER == $past(pc_next))
        else $error("program counter did not advance");
    jump_target_a: assert property (took_s ##0 INSTR[22:18] == {FMT_JUMP, KIND_JUMP}
        |=> PROGRAM_COUNTER == $past(INSTR[12:2])) else $error("jump target not loaded");
    quiet_host_a: assert property (took_op_s ##0 INSTR[7:4] == SOURCE_HOST_QUIET && INSTR[3:0] != DEST_HOST
        |=> !DECODE.host_flag_set && !DECODE.dma_raise) else $error("quiet host read raised a flag");
endmodule : dec_chk
bind dsp_instruction_field_decoder dec_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .DECODE(DECODE), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .DATA_POINTER(DATA_POINTER), .COEF_POINTER(COEF_POINTER));
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: register access, corner words and a random instruction stream
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb;
    import dsp_decode_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0, iv = 0, dma = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000605A;
    logic [22:0] instr = 23'h0;
    logic [15:0] busv = 16'h0;
    logic [10:0] pc, pc_m = 11'h0;
    logic [6:0] dp, dp_m = 7'h0;
    logic [8:0] rp, rp_m = 9'h0;
    logic [10:0] stk[$];
    cond_flags_t flags = '0;
    decode_t dec;
    int n_fail = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    dsp_instruction_field_decoder dut (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .INSTR_VALID(iv), .INSTR(instr), .BUS_VALUE(busv), .FLAGS(flags), .DMA_MODE(dma), .DECODE(dec),
        .PROGRAM_COUNTER(pc), .DATA_POINTER(dp), .COEF_POINTER(rp));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    // Read data is expected in d; a gap cycle follows so psel is never driven twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
        int n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) n_fail++;
        `CHK(pslverr, err)
        if (!w) `CHK(prdata, d)
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic step(input logic [22:0] i);
        logic [6:0] od;
        logic [3:0] d, s, c;
        logic t;
        iv <= 1'b1;
        instr <= i;
        @(posedge clk);
        iv <= 1'b0;
        {od, s, d, c} = {dp_m, i[7:0], i[17:14]};
        t = c == 4'hC ? (i[13] ? &od[3:0] : ~|od[3:0]) : flags[c < 4'hC ? 14 - c : 15 - c] == i[13];
        pc_m = pc_m + 11'h001;
        if (i[22:21] == FMT_JUMP && (i[20:18] != KIND_COND || t)) begin
            if (i[20:18] == KIND_CALL && stk.size() == 4) stk[3] = pc_m;
            else if (i[20:18] == KIND_CALL) stk.push_back(pc_m);
            pc_m = i[12:2];
        end
        if (!i[22]) begin
            dp_m[3:0] = i[13:12] == LOW_CLEAR ? 4'h0 : dp_m[3:0] + (i[12] ? 4'h1 : {4{i[13]}});
            dp_m[6:4] ^= i[11:9];
            rp_m = rp_m - {8'h00, i[8]};
            if (i[21] && stk.size() > 0) pc_m = stk.pop_back();
        end
        @(negedge clk);
        `CHK({dec.valid, pc, dp, rp}, {1'b1, pc_m, dp_m, rp_m})
        if (i[22:21] == FMT_LOAD) `CHK({dec.dest, dec.immediate_value}, {d, i[20:5]})
        if (!i[22]) `CHK({dec.acc_b, dec.source, dec.dest, dec.returning}, {i[14], s, d, i[21]})
        t = s == 4'h8 || d == 4'h6;
        if (!i[22]) `CHK({dec.host_flag_set, dec.dma_raise}, {t, t && dma})
        if (!i[22]) `CHK({dec.serial_in_read, dec.serial_in_reversed}, {s == 4'hB || s == 4'hC, s == 4'hC})
        if (i[22:21] != FMT_JUMP) begin
            `CHK({dec.serial_out_load, dec.serial_out_msb_first}, {d[3:1] == 3'h4, d == 4'h9})
            `CHK({dec.factor1_from_bus, dec.factor2_from_rom}, {d == 4'hA || d == 4'hB, d == 4'hB})
            `CHK({dec.factor1_from_ram, dec.factor2_from_bus}, {d == 4'hC, d == 4'hC || d == 4'hD})
            if (d == 4'hC) `CHK(dec.factor_ram_addr, od | 7'h40)
        end
        @(posedge clk);
    endtask : step
    function automatic logic [22:0] gen();
        logic [22:0] i;
        i = 23'(rnd());
        // Pointer-loading destinations left out: the bus value mapping is not fixed
        if (i[3:1] == 3'h2) i[3:0] = DEST_NONE;
        if (i[22:21] == FMT_JUMP) i[20:18] = i[19] ? KIND_COND : (i[18] ? KIND_CALL : KIND_JUMP);
        if (i[22:21] == FMT_JUMP && !i[19]) i[17:13] = 5'h00;
        return i;
    endfunction : gen
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h1, 1'b0);
        apb(1'b0, 8'h40, 32'h0, 1'b1);
        apb(1'b1, ADDR_PC, 32'h7FF, 1'b0);
        apb(1'b1, ADDR_POINTERS, 32'hF, 1'b0);
        apb(1'b0, ADDR_POINTERS, 32'hF, 1'b0);
        {pc_m, dp_m} = {11'h7FF, 7'h0F};
        step(23'h001100);
        step(23'h007E00);
        step(23'h200000);
        apb(1'b0, ADDR_STATUS, 32'h4, 1'b0);
        apb(1'b1, ADDR_STATUS, 32'h4, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
        ce <= 1'b0;
        iv <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        iv <= 1'b0;
        @(negedge clk);
        `CHK({dec.valid, pc, dp, rp}, {1'b0, pc_m, dp_m, rp_m})
        @(posedge clk);
        repeat (3000) begin
            flags <= cond_flags_t'(rnd());
            dma <= 1'(rnd());
            busv <= 16'(rnd());
            step(gen());
        end
        final_report();
    end
    initial begin
        #40us;
        n_fail++;
        final_report();
    end
endmodule : tb
`default_nettype wire
